// >>> rtl/tcc_capture_compare.sv
// Top of the 16-bit timer input capture and output compare logic
`timescale 1ns/1ps
module tcc_capture_compare
    import tcc_pkg::*;
(
    input  wire logic         i_sys_clk,
    input  wire logic         i_reset_n,
    input  wire logic         i_clk_en,
    input  wire logic         i_capture_input_pin,
    input  wire logic         i_comparator_result,
    input  wire tcc_cfg_t     i_cfg,
    input  wire tcc_count_t   i_count,
    input  wire tcc_cpu_wr_t  i_cpu,
    input  wire logic         i_capture_irq_ack,
    input  wire logic [1:0]   i_compare_irq_ack,
    output logic [15:0]       o_capture_value,
    output logic              o_capture_flag,
    output logic              o_capture_irq,
    output logic [1:0]        o_compare_flag,
    output logic [1:0]        o_compare_irq,
    output logic [1:0]        o_compare_output,
    output logic [1:0]        o_compare_match,
    output logic [15:0]       o_compare_read_a,
    output logic [15:0]       o_compare_read_b,
    output logic [15:0]       o_top_value_a
);
    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    logic [1:0]  pin_sync;
    logic [1:0]  cmp_sync;
    logic        trigger;
    logic        edge_event;
    logic        capture_now;
    logic        pwm;
    logic        icr_top;
    logic        update_point;
    logic [7:0]  high_latch;
    logic [7:0]  next_high_latch;
    logic [15:0] wr_data;
    logic        block;
    logic        next_block;
    logic [15:0] next_capture_value;
    logic        next_capture_flag;
    logic        next_capture_irq;
    logic [1:0]  next_compare_irq;
    logic [15:0] next_read_a;
    logic [15:0] next_read_b;
    logic [15:0] buf_val [NUM_CMP];
    logic [15:0] act_val [NUM_CMP];
    logic [1:0]  unit_flag;
    logic [1:0]  unit_out;
    logic [1:0]  unit_match;

    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            pin_sync <= 2'h0;
            cmp_sync <= 2'h0;
        end else if (i_clk_en) begin
            pin_sync <= {pin_sync[0], i_capture_input_pin};
            cmp_sync <= {cmp_sync[0], i_comparator_result};
        end
    end

    // ----------------------------------------
    // Trigger selection and mode decode
    // ----------------------------------------
    always_comb begin
        trigger      = i_cfg.comparator_capture_select ? cmp_sync[1] : pin_sync[1];
        pwm          = tcc_is_pwm(i_cfg.waveform_mode_sel);
        icr_top      = tcc_icr_top(i_cfg.waveform_mode_sel);
        update_point = i_count.tick && (tcc_bottom_update(i_cfg.waveform_mode_sel)
                                        ? i_count.at_bottom : i_count.at_top);
        capture_now  = edge_event && !icr_top;
        wr_data      = {high_latch, i_cpu.wdata};
    end

    tcc_capture_filter #(
        .SAMPLES (FILT_SAMPLES)
    ) u_filter (
        .i_sys_clk       (i_sys_clk),
        .i_reset_n       (i_reset_n),
        .i_clk_en        (i_clk_en),
        .i_sample        (trigger),
        .i_filter_enable (i_cfg.capture_filter_enable),
        .i_rising_edge   (i_cfg.capture_rising_edge),
        .o_event         (edge_event)
    );

    // ----------------------------------------
    // Capture register, flags, latch and read-back
    // ----------------------------------------
    always_comb begin
        next_capture_value = o_capture_value;
        next_capture_flag  = o_capture_flag;
        if (i_cpu.capture_flag_clr || i_capture_irq_ack) begin
            next_capture_flag = 1'b0;
        end
        if (capture_now) begin
            next_capture_value = i_count.counter_value;
            next_capture_flag  = 1'b1;
        end
        next_capture_irq = o_capture_flag && i_cfg.capture_irq_enable;
        next_compare_irq = unit_flag & i_cfg.compare_irq_enable;
        next_high_latch  = (|i_cpu.wr_high) ? i_cpu.wdata : high_latch;
        if (i_cpu.counter_write) begin
            next_block = 1'b1;
        end else if (i_count.tick) begin
            next_block = 1'b0;
        end else begin
            next_block = block;
        end
        next_read_a = pwm ? buf_val[0] : act_val[0];
        next_read_b = pwm ? buf_val[1] : act_val[1];
    end

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_capture_value  <= VALUE_RST;
            o_capture_flag   <= 1'b0;
            o_capture_irq    <= 1'b0;
            o_compare_irq    <= 2'h0;
            o_compare_flag   <= 2'h0;
            o_compare_output <= 2'h0;
            o_compare_match  <= 2'h0;
            o_compare_read_a <= VALUE_RST;
            o_compare_read_b <= VALUE_RST;
            o_top_value_a    <= VALUE_RST;
            high_latch       <= LATCH_RST;
            block            <= 1'b0;
        end else if (i_clk_en) begin
            o_capture_value  <= next_capture_value;
            o_capture_flag   <= next_capture_flag;
            o_capture_irq    <= next_capture_irq;
            o_compare_irq    <= next_compare_irq;
            o_compare_flag   <= unit_flag;
            o_compare_output <= unit_out;
            o_compare_match  <= unit_match;
            o_compare_read_a <= next_read_a;
            o_compare_read_b <= next_read_b;
            o_top_value_a    <= act_val[0];
            high_latch       <= next_high_latch;
            block            <= next_block;
        end
    end

    // ----------------------------------------
    // Compare units
    // ----------------------------------------
    for (genvar u = 0; u < NUM_CMP; u++) begin : g_unit
        tcc_compare_unit u_cmp (
            .i_sys_clk       (i_sys_clk),
            .i_reset_n       (i_reset_n),
            .i_clk_en        (i_clk_en),
            .i_pwm           (pwm),
            .i_update        (update_point),
            .i_tick          (i_count.tick),
            .i_block         (block),
            .i_counter_value (i_count.counter_value),
            .i_wr_low        (i_cpu.wr_low[u]),
            .i_wr_data       (wr_data),
            .i_action        (i_cfg.compare_output_action[2*u +: 2]),
            .i_force         (i_cpu.force_compare_strobe[u]),
            .i_flag_clr      (i_cpu.compare_flag_clr[u] || i_compare_irq_ack[u]),
            .o_buffer        (buf_val[u]),
            .o_active        (act_val[u]),
            .o_flag          (unit_flag[u]),
            .o_out           (unit_out[u]),
            .o_match         (unit_match[u])
        );
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    property p_capture_copy;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        (i_clk_en && capture_now) |=> (o_capture_value == $past(i_count.counter_value)) && o_capture_flag;
    endproperty
    a_capture_copy: assert property (p_capture_copy)
        else $error("capture did not copy counter and set flag together");

    property p_icr_top_blocks;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        (i_clk_en && icr_top && !o_capture_flag && !i_cpu.counter_write)
            |=> ($stable(o_capture_value) || !$past(icr_top));
    endproperty
    a_icr_top_blocks: assert property (p_icr_top_blocks)
        else $error("capture happened in a mode using capture value as TOP");

    property p_match_flag;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        (i_clk_en && i_count.tick && !block && i_count.counter_value == act_val[0])
            |=> unit_flag[0] ##1 (o_compare_flag[0] || !$past(i_clk_en));
    endproperty
    a_match_flag: assert property (p_match_flag)
        else $error("compare match did not set flag A");

    property p_write_blocks;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        (i_clk_en && block && !unit_flag[1]) |=> !unit_match[1];
    endproperty
    a_write_blocks: assert property (p_write_blocks)
        else $error("compare match not blocked after counter write");

    property p_low_write;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        (i_clk_en && i_cpu.wr_low[0] && !i_cpu.wr_high[0]) |=> (buf_val[0] == $past(wr_data));
    endproperty
    a_low_write: assert property (p_low_write)
        else $error("low byte write did not load latched sixteen bits");

    property p_direct_write;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        (i_clk_en && !pwm && i_cpu.wr_low[1]) |=> (act_val[1] == $past(wr_data));
    endproperty
    a_direct_write: assert property (p_direct_write)
        else $error("non-PWM write did not reach active compare value");

    property p_pwm_hold;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        (i_clk_en && pwm && !update_point) |=> $stable(act_val[0]);
    endproperty
    a_pwm_hold: assert property (p_pwm_hold)
        else $error("buffered compare value changed away from TOP or BOTTOM");

    property p_force_no_flag;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        (i_clk_en && !pwm && i_cpu.force_compare_strobe[0] && !i_count.tick && !unit_flag[0])
            |=> !unit_flag[0];
    endproperty
    a_force_no_flag: assert property (p_force_no_flag)
        else $error("force strobe set the compare flag");

    property p_no_action;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        (i_clk_en && i_cfg.compare_output_action[1:0] == ACT_NONE) |=> $stable(unit_out[0]);
    endproperty
    a_no_action: assert property (p_no_action)
        else $error("compare output changed with action zero");

    property p_irq;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        (i_clk_en && unit_flag[0] && i_cfg.compare_irq_enable[0]) |=> o_compare_irq[0];
    endproperty
    a_irq: assert property (p_irq)
        else $error("enabled compare flag did not request interrupt");

    property p_read_back;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        (i_clk_en && pwm) |=> (o_compare_read_b == $past(buf_val[1]));
    endproperty
    a_read_back: assert property (p_read_back)
        else $error("PWM read did not return the buffer");
endmodule : tcc_capture_compare

// >>> rtl/tcc_capture_filter.sv
// Capture input filter and edge detector
`timescale 1ns/1ps
module tcc_capture_filter
    import tcc_pkg::*;
#(
    parameter int SAMPLES = FILT_SAMPLES
) (
    input  wire logic i_sys_clk,
    input  wire logic i_reset_n,
    input  wire logic i_clk_en,
    input  wire logic i_sample,
    input  wire logic i_filter_enable,
    input  wire logic i_rising_edge,
    output logic      o_event
);
    logic [SAMPLES-1:0] hist;
    logic [SAMPLES-1:0] next_hist;
    logic               filt;
    logic               next_filt;
    logic               next_event;

    // ----------------------------------------
    // Filter and edge detection
    // ----------------------------------------
    always_comb begin
        next_hist = {hist[SAMPLES-2:0], i_sample};
        if (!i_filter_enable) begin
            next_filt = i_sample;
        end else if (&hist || ~|hist) begin
            next_filt = hist[SAMPLES-1];
        end else begin
            next_filt = filt;
        end
        next_event = (next_filt != filt) && (next_filt == i_rising_edge);
    end

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            hist    <= '0;
            filt    <= 1'b0;
            o_event <= 1'b0;
        end else if (i_clk_en) begin
            hist    <= next_hist;
            filt    <= next_filt;
            o_event <= next_event;
        end
    end

    property p_filter_stable;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        (i_clk_en && i_filter_enable && $past(i_clk_en) && $past(i_filter_enable) && filt != $past(filt))
            |-> ($past(hist) == {SAMPLES{filt}});
    endproperty
    a_filter_stable: assert property (p_filter_stable)
        else $error("filter output changed without four equal samples");
endmodule : tcc_capture_filter

// >>> rtl/tcc_compare_unit.sv
// One output compare unit with buffer, active value, flag and output state
`timescale 1ns/1ps
module tcc_compare_unit
    import tcc_pkg::*;
(
    input  wire logic        i_sys_clk,
    input  wire logic        i_reset_n,
    input  wire logic        i_clk_en,
    input  wire logic        i_pwm,
    input  wire logic        i_update,
    input  wire logic        i_tick,
    input  wire logic        i_block,
    input  wire logic [15:0] i_counter_value,
    input  wire logic        i_wr_low,
    input  wire logic [15:0] i_wr_data,
    input  wire logic [1:0]  i_action,
    input  wire logic        i_force,
    input  wire logic        i_flag_clr,
    output logic [15:0]      o_buffer,
    output logic [15:0]      o_active,
    output logic             o_flag,
    output logic             o_out,
    output logic             o_match
);
    logic [15:0] next_buffer;
    logic [15:0] next_active;
    logic        next_flag;
    logic        next_out;
    logic        next_match;
    logic        hit;

    // ----------------------------------------
    // Match, buffering and output action
    // ----------------------------------------
    always_comb begin
        next_buffer = o_buffer;
        next_active = o_active;
        next_flag   = o_flag;
        next_out    = o_out;
        next_match  = 1'b0;
        hit         = i_tick && !i_block && (i_counter_value == o_active);
        if (i_pwm && i_update) begin
            next_active = o_buffer;
        end
        if (i_wr_low) begin
            next_buffer = i_wr_data;
            if (!i_pwm) begin
                next_active = i_wr_data;
            end
        end
        if (i_flag_clr) begin
            next_flag = 1'b0;
        end
        if (hit) begin
            next_flag  = 1'b1;
            next_match = 1'b1;
            next_out   = tcc_apply(o_out, i_action);
        end else if (i_force && !i_pwm) begin
            next_out = tcc_apply(o_out, i_action);
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_buffer <= VALUE_RST;
            o_active <= VALUE_RST;
            o_flag   <= 1'b0;
            o_out    <= 1'b0;
            o_match  <= 1'b0;
        end else if (i_clk_en) begin
            o_buffer <= next_buffer;
            o_active <= next_active;
            o_flag   <= next_flag;
            o_out    <= next_out;
            o_match  <= next_match;
        end
    end
endmodule : tcc_compare_unit

// >>> rtl/tcc_pkg.sv
// Shared constants, types and helper functions of the timer capture/compare block
// Operation
// - Capture pin triggers by default; comparator result when select bit is set.
// - Changing trigger source may capture; software clears the capture flag afterwards.
// - Enabled filter adds four system clocks before the capture register updates.
// - Capture input is disabled only in modes using capture value as TOP.
// - Pin level is sampled whoever drives it, so software can force captures.
// - Filter output changes only after four equal consecutive input samples.
// - Filter enable lives in timer_ctrl_b; filter runs on undivided system clock.
// - Every capture overwrites the capture value, read or not.
// - Counter compared with each compare value; match sets flag at the clock edge of the matching timer tick.
// - Enabled flag raises interrupt; cleared on service or by writing one.
// - Compare unit A value can serve as counter TOP.
// - Compare values buffered in twelve PWM modes; direct in normal and clear-on-match.
// - Buffer moves to active compare value only at TOP or BOTTOM.
// - Reads return buffer when buffering, else active value; no high-byte latch.
// - High byte goes to shared latch; low byte write loads all sixteen bits.
// - Force strobe in non-PWM modes acts like match, without flag or counter effect.
// - Capture copies counter and sets capture flag in the same cycle.
// - Counter write blocks every compare match in the next timer tick.
// - Output action zero leaves compare output unchanged on match.
package tcc_pkg;
    localparam int          CNT_W        = 16;
    localparam int          BYTE_W       = 8;
    localparam int          NUM_CMP      = 2;
    localparam int          FILT_SAMPLES = 4;
    localparam logic [3:0]  WGM_NORMAL   = 4'h0;
    localparam logic [3:0]  WGM_CTC_A    = 4'h4;
    localparam logic [3:0]  WGM_CTC_ICR  = 4'hC;
    localparam logic [3:0]  WGM_RSVD     = 4'hD;
    localparam logic [3:0]  WGM_PFC_ICR  = 4'h8;
    localparam logic [3:0]  WGM_PFC_A    = 4'h9;
    localparam logic [3:0]  WGM_PC_ICR   = 4'hA;
    localparam logic [3:0]  WGM_FAST_ICR = 4'hE;
    localparam logic [1:0]  ACT_NONE     = 2'h0;
    localparam logic [1:0]  ACT_TOGGLE   = 2'h1;
    localparam logic [1:0]  ACT_CLEAR    = 2'h2;
    localparam logic [1:0]  ACT_SET      = 2'h3;
    localparam logic [15:0] VALUE_RST    = 16'h0000;
    localparam logic [7:0]  LATCH_RST    = 8'h00;

    typedef struct packed {
        logic [3:0] waveform_mode_sel;
        logic [3:0] compare_output_action;
        logic       comparator_capture_select;
        logic       capture_filter_enable;
        logic       capture_rising_edge;
        logic [1:0] compare_irq_enable;
        logic       capture_irq_enable;
    } tcc_cfg_t;

    typedef struct packed {
        logic        tick;
        logic        at_top;
        logic        at_bottom;
        logic [15:0] counter_value;
    } tcc_count_t;

    typedef struct packed {
        logic [7:0] wdata;
        logic [1:0] wr_high;
        logic [1:0] wr_low;
        logic [1:0] force_compare_strobe;
        logic [1:0] compare_flag_clr;
        logic       capture_flag_clr;
        logic       counter_write;
    } tcc_cpu_wr_t;

    function automatic logic tcc_is_pwm(input logic [3:0] mode);
        tcc_is_pwm = !(mode == WGM_NORMAL || mode == WGM_CTC_A || mode == WGM_CTC_ICR || mode == WGM_RSVD);
    endfunction : tcc_is_pwm

    function automatic logic tcc_icr_top(input logic [3:0] mode);
        tcc_icr_top = (mode == WGM_PFC_ICR || mode == WGM_PC_ICR || mode == WGM_CTC_ICR || mode == WGM_FAST_ICR);
    endfunction : tcc_icr_top

    function automatic logic tcc_bottom_update(input logic [3:0] mode);
        tcc_bottom_update = (mode == WGM_PFC_ICR || mode == WGM_PFC_A);
    endfunction : tcc_bottom_update

    function automatic logic tcc_apply(input logic cur, input logic [1:0] act);
        case (act)
            ACT_TOGGLE: tcc_apply = !cur;
            ACT_CLEAR:  tcc_apply = 1'b0;
            ACT_SET:    tcc_apply = 1'b1;
            default:    tcc_apply = cur;
        endcase
    endfunction : tcc_apply
endpackage : tcc_pkg

// >>> verification/tcc_signal_source.sv
// External capture signal source for the capture pin and comparator result
`timescale 1ns/1ps
module tcc_signal_source (
    input  wire logic i_sys_clk,
    input  wire logic i_level,
    input  wire logic i_cmp_level,
    input  wire logic i_glitch,
    output logic      o_pin,
    output logic      o_comparator
);
    int glitch_left = 0;

    // Short inverted pulse for filter tests
    always @(posedge i_sys_clk) begin
        if (i_glitch)
            glitch_left <= 3;
        else if (glitch_left > 0)
            glitch_left <= glitch_left - 1;
    end

    assign o_pin        = i_level ^ (glitch_left > 0);
    assign o_comparator = i_cmp_level;
endmodule : tcc_signal_source

// >>> verification/test_tcc_capture_compare.sv
// Self-checking testbench of the timer capture/compare block
`timescale 1ns/1ps
module test_tcc_capture_compare;
    import tcc_pkg::*;
    logic        sys_clk = 1'b0;
    logic        reset_n = 1'b0;
    logic        clk_en = 1'b1;
    logic        level = 1'b0;
    logic        cmp_level = 1'b0;
    logic        glitch = 1'b0;
    logic        pin, comp, cap_flag, cap_irq;
    tcc_cfg_t    cfg = '0;
    tcc_count_t  cnt = '0;
    tcc_cpu_wr_t cpu = '0;
    logic        cap_ack = 1'b0;
    logic [1:0]  cmp_ack = 2'h0;
    logic [1:0]  cmp_flag, cmp_irq, cmp_out, cmp_match;
    logic [15:0] cap_value, read_a, read_b, top_a, va, vb;
    int          miscompares = 0;
    int          total_checks = 0;
    int          cycles = 0;
    integer      seed = 32'hC3AB221A;

    tcc_signal_source i_tcc_signal_source (.i_sys_clk(sys_clk), .i_level(level), .i_cmp_level(cmp_level),
        .i_glitch(glitch), .o_pin(pin), .o_comparator(comp));

    tcc_capture_compare i_tcc_capture_compare (.i_sys_clk(sys_clk), .i_reset_n(reset_n), .i_clk_en(clk_en),
        .i_capture_input_pin(pin), .i_comparator_result(comp), .i_cfg(cfg), .i_count(cnt), .i_cpu(cpu),
        .i_capture_irq_ack(cap_ack), .i_compare_irq_ack(cmp_ack), .o_capture_value(cap_value),
        .o_capture_flag(cap_flag), .o_capture_irq(cap_irq), .o_compare_flag(cmp_flag), .o_compare_irq(cmp_irq),
        .o_compare_output(cmp_out), .o_compare_match(cmp_match), .o_compare_read_a(read_a),
        .o_compare_read_b(read_b), .o_top_value_a(top_a));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    initial begin
        forever #50 sys_clk = ~sys_clk;
    end

    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : step

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic end_of_test;
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : end_of_test

    task automatic clr_cap;
        cpu.capture_flag_clr = 1'b1;
        step(1);
        cpu.capture_flag_clr = 1'b0;
        step(1);
        check("cap_clr", {15'h0, cap_flag}, 16'h0000);
    endtask : clr_cap

    task automatic capture(input logic lvl, input int lat, input logic fire, input logic pre);
        logic [15:0] cv;
        cv = 16'($random(seed));
        cnt.counter_value = cv;
        if (cfg.comparator_capture_select)
            cmp_level = lvl;
        else
            level = lvl;
        step(lat - 1);
        check("cap_early", {15'h0, cap_flag}, {15'h0, pre});
        step(1);
        check("cap_flag", {15'h0, cap_flag}, {15'h0, pre | fire});
        if (fire)
            check("cap_value", cap_value, cv);
    endtask : capture

    task automatic wr(input int hu, input int lu, input logic [15:0] v);
        cpu.wdata = v[15:8];
        cpu.wr_high[hu] = 1'b1;
        step(1);
        cpu.wr_high = 2'h0;
        cpu.wdata = v[7:0];
        cpu.wr_low[lu] = 1'b1;
        step(1);
        cpu.wr_low = 2'h0;
        step(1);
    endtask : wr

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 2000) begin
            miscompares++;
            end_of_test();
        end
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        cfg.capture_rising_edge = 1'b1;
        cfg.capture_irq_enable = 1'b1;
        cfg.compare_irq_enable = 2'h1;
        step(4);
        reset_n = 1'b1;
        step(1);
        capture(1'b1, 4, 1'b1, 1'b0);
        step(1);
        check("cap_irq", {15'h0, cap_irq}, 16'h0001);
        cfg.capture_rising_edge = 1'b0;
        capture(1'b0, 4, 1'b1, 1'b1);
        cfg.capture_filter_enable = 1'b1;
        cfg.capture_rising_edge = 1'b1;
        clr_cap();
        capture(1'b1, 8, 1'b1, 1'b0);
        cfg.capture_rising_edge = 1'b0;
        clr_cap();
        glitch = 1'b1;
        step(1);
        glitch = 1'b0;
        capture(1'b1, 12, 1'b0, 1'b0);
        cfg.capture_filter_enable = 1'b0;
        cfg.capture_rising_edge = 1'b1;
        cfg.comparator_capture_select = 1'b1;
        step(8);
        clr_cap();
        capture(1'b1, 4, 1'b1, 1'b0);
        cfg.waveform_mode_sel = WGM_CTC_ICR;
        cfg.capture_rising_edge = 1'b0;
        clr_cap();
        capture(1'b0, 12, 1'b0, 1'b0);
        cfg.waveform_mode_sel = WGM_NORMAL;
        va = 16'($random(seed));
        vb = 16'($random(seed));
        cnt.counter_value = va ^ vb ^ 16'h5A5A;
        wr(0, 0, va);
        wr(0, 1, vb);
        check("read_a", read_a, va);
        check("read_b", read_b, vb);
        check("top_a", top_a, va);
        cfg.waveform_mode_sel = 4'h1;
        wr(0, 0, ~va);
        check("read_buf", read_a, ~va);
        cnt.tick = 1'b1;
        step(1);
        cnt.tick = 1'b0;
        step(2);
        check("top_hold", top_a, va);
        cnt.tick = 1'b1;
        cnt.at_top = 1'b1;
        step(1);
        cnt.tick = 1'b0;
        cnt.at_top = 1'b0;
        step(2);
        check("top_load", top_a, ~va);
        cfg.waveform_mode_sel = WGM_NORMAL;
        cfg.compare_output_action = 4'h1;
        wr(1, 1, ~va);
        cnt.counter_value = ~va;
        cnt.tick = 1'b1;
        step(1);
        cnt.tick = 1'b0;
        step(1);
        check("cmp_flag", {14'h0, cmp_flag}, 16'h0003);
        check("cmp_match", {14'h0, cmp_match}, 16'h0003);
        check("cmp_out", {14'h0, cmp_out}, 16'h0001);
        check("cmp_irq", {14'h0, cmp_irq}, 16'h0001);
        step(1);
        check("match_pulse", {14'h0, cmp_match}, 16'h0000);
        cmp_ack = 2'h1;
        cpu.compare_flag_clr = 2'h2;
        step(1);
        cmp_ack = 2'h0;
        cpu.compare_flag_clr = 2'h0;
        step(2);
        check("cmp_clr", {14'h0, cmp_flag}, 16'h0000);
        cpu.counter_write = 1'b1;
        step(1);
        cpu.counter_write = 1'b0;
        cnt.tick = 1'b1;
        step(1);
        cnt.tick = 1'b0;
        step(2);
        check("blocked", {14'h0, cmp_flag}, 16'h0000);
        check("blk_out", {14'h0, cmp_out}, 16'h0001);
        cpu.force_compare_strobe = 2'h1;
        step(1);
        cpu.force_compare_strobe = 2'h0;
        step(2);
        check("force_out", {14'h0, cmp_out}, 16'h0000);
        check("force_flag", {14'h0, cmp_flag}, 16'h0000);
        clk_en = 1'b0;
        cpu.force_compare_strobe = 2'h1;
        step(1);
        cpu.force_compare_strobe = 2'h0;
        step(2);
        clk_en = 1'b1;
        step(2);
        check("frozen_out", {14'h0, cmp_out}, 16'h0000);
        end_of_test();
    end
endmodule : test_tcc_capture_compare
